/* hw/pcrb_unit.sv */
`timescale 1ns/100ps
`include "pcrb_defs.svh"
// Summary of operation
// - Displacement is immediate with two zero bits
// - Sign-extend displacement to register width
// - Target is delay-slot address plus displacement
// - Equal-likely taken when both sources match
// - Nonneg family taken when sign bit zero
// - Ordinary branches always run delay slot
// - Not-taken likely branch squashes delay slot
// - Link forms write branch plus eight always
// - Re-executed branch reevaluates from register state
// - These branches raise no exception
// - Link with register zero always calls
// - Likely branches are not predicted taken
module pcrb_unit #(
  parameter int GPR_W = 32
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_valid,
  input  wire pcrb_pkg::pcrb_req_s i_req,
  input  wire logic [GPR_W-1:0]   i_rs_val,
  input  wire logic [GPR_W-1:0]   i_rt_val,
  output logic                    o_redirect,
  output logic [GPR_W-1:0]        o_target,
  output logic                    o_squash_slot,
  output logic                    o_link_we,
  output logic [4:0]              o_link_reg,
  output logic [GPR_W-1:0]        o_link_data,
  output logic                    o_exception
);

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Used only for the delay-slot squash decode; link forms use is_link
  function automatic logic is_likely(input pcrb_pkg::pcrb_op_e op);
    is_likely = (op == pcrb_pkg::PCRB_OP_BRANCH_EQUAL_LIKELY) ||
                (op == pcrb_pkg::PCRB_OP_BRANCH_NONNEG_LIKELY) ||
                (op == pcrb_pkg::PCRB_OP_BRANCH_NONNEG_LINK_LIKELY);
  endfunction : is_likely

  function automatic logic is_link(input pcrb_pkg::pcrb_op_e op);
    is_link = (op == pcrb_pkg::PCRB_OP_BRANCH_NONNEG_LINK) ||
              (op == pcrb_pkg::PCRB_OP_BRANCH_NONNEG_LINK_LIKELY);
  endfunction : is_link

  // ==========================================================
  // Operand fetch and condition
  // ==========================================================
  logic [GPR_W-1:0] rs_eff;
  logic [GPR_W-1:0] rt_eff;
  logic             cond;
  logic             known_op;

  // Register zero forced to zero so the file port need not guarantee it
  assign rs_eff = (i_req.rs == `PCRB_ZERO_REG) ? '0 : i_rs_val;
  assign rt_eff = (i_req.rt == `PCRB_ZERO_REG) ? '0 : i_rt_val;

  // Condition is pure function of register values, so re-execution repeats it
  always_comb begin
    cond     = 1'b0;
    known_op = 1'b1;
    case (i_req.op)
      pcrb_pkg::PCRB_OP_BRANCH_EQUAL_LIKELY: begin
        cond = (rs_eff == rt_eff);
      end
      pcrb_pkg::PCRB_OP_BRANCH_NONNEG,
      pcrb_pkg::PCRB_OP_BRANCH_NONNEG_LIKELY,
      pcrb_pkg::PCRB_OP_BRANCH_NONNEG_LINK,
      pcrb_pkg::PCRB_OP_BRANCH_NONNEG_LINK_LIKELY: begin
        // Zero source has a clear sign bit, so the link form always calls
        cond = ~rs_eff[GPR_W-1];
      end
      default: begin
        known_op = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Target and link arithmetic
  // ==========================================================
  logic [`PCRB_DISP_W-1:0] disp_short;
  logic [GPR_W-1:0]        disp;
  logic [GPR_W-1:0]        slot_pc;
  logic [GPR_W-1:0]        next_target;
  logic [GPR_W-1:0]        next_link;

  assign disp_short  = {i_req.imm, {`PCRB_DISP_SHIFT{1'b0}}};
  assign disp        = {{(GPR_W-`PCRB_DISP_W){disp_short[`PCRB_DISP_W-1]}},
                        disp_short};
  // Base is the delay slot, not the branch itself
  assign slot_pc     = GPR_W'(i_req.pc) + GPR_W'(`PCRB_SLOT_OFS);
  assign next_target = slot_pc + disp;
  assign next_link   = GPR_W'(i_req.pc) + GPR_W'(`PCRB_LINK_OFS);

  logic fire;
  assign fire = i_valid && known_op;

  // ==========================================================
  // Redirect, registered so PC loads in the cycle after the branch
  // ==========================================================
  // One cycle of latency lets the slot issue first; next fetch then follows
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_redirect <= 1'b0;
      o_target   <= '0;
    end else begin
      o_redirect <= fire && cond;
      o_target   <= next_target;
    end
  end

  // ==========================================================
  // Delay-slot squash
  // ==========================================================
  // Ordinary branches never squash; only a failed likely branch does
  // No static prediction, so a miss costs only the squashed slot
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_squash_slot <= 1'b0;
    end else begin
      o_squash_slot <= fire && is_likely(i_req.op) && !cond;
    end
  end

  // ==========================================================
  // Link writeback
  // ==========================================================
  // Written whether or not taken; a source of 31 is left to software
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_link_we   <= 1'b0;
      o_link_reg  <= '0;
      o_link_data <= '0;
    end else begin
      o_link_we   <= fire && is_link(i_req.op);
      o_link_reg  <= `PCRB_LINK_REG;
      o_link_data <= next_link;
    end
  end

  // These branches never trap
  assign o_exception = 1'b0;

  // ==========================================================
  // Checks
  // ==========================================================
  redirect_when_taken_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (fire && cond) |=> (o_redirect && o_target == $past(next_target)))
    else $error("taken branch did not redirect to slot plus displacement");

  target_slot_base_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fire |=> o_target == $past(i_req.pc) + 32'h4
      + {{14{$past(i_req.imm[15])}}, $past(i_req.imm), 2'b00})
    else $error("target not slot address plus shifted immediate");

  equal_compare_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_req.op == pcrb_pkg::PCRB_OP_BRANCH_EQUAL_LIKELY)
      |=> o_redirect == ($past(rs_eff) == $past(rt_eff)))
    else $error("equal likely resolved wrongly");

  sign_test_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_req.op == pcrb_pkg::PCRB_OP_BRANCH_NONNEG)
      |=> o_redirect == !$past(i_rs_val[GPR_W-1] && i_req.rs != 5'h00))
    else $error("nonneg test wrong");

  ordinary_no_squash_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && !is_likely(i_req.op)) |=> !o_squash_slot)
    else $error("ordinary branch squashed its slot");

  likely_squash_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_squash_slot |-> !o_redirect && $past(is_likely(i_req.op)))
    else $error("squash without failed likely branch");

  link_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && is_link(i_req.op)) |=>
      (o_link_we && o_link_reg == 5'h1F && o_link_data == $past(i_req.pc) + 32'h8))
    else $error("link not written with branch plus eight");

  zero_call_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_req.op == pcrb_pkg::PCRB_OP_BRANCH_NONNEG_LINK && i_req.rs == 5'h00)
      |=> (o_redirect && o_link_we))
    else $error("link with zero source did not call");

  no_exception_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_exception)
    else $error("branch raised exception");

  likely_miss_squash_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (fire && is_likely(i_req.op) && !cond) |=> (o_squash_slot && !o_redirect))
    else $error("failed likely branch kept its slot");

  idle_no_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !fire |=> !(o_redirect || o_squash_slot || o_link_we))
    else $error("pulse without an accepted branch");

  link_regardless_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (fire && is_link(i_req.op) && !cond) |=> (o_link_we && !o_redirect))
    else $error("untaken link branch skipped its link write");

  zero_source_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (fire && i_req.rs == 5'h00 && i_req.op != pcrb_pkg::PCRB_OP_BRANCH_EQUAL_LIKELY)
      |=> o_redirect)
    else $error("register zero not read as zero");

  cov_taken_c:      cover property (@(posedge i_clk) disable iff (!i_rst_n) o_redirect);
  cov_squash_c:     cover property (@(posedge i_clk) disable iff (!i_rst_n) o_squash_slot);
  cov_link_miss_c:  cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_link_we && !o_redirect);
  cov_back_back_c:  cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_redirect ##1 o_redirect);
  cov_link_squash_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_link_we && o_squash_slot);

endmodule : pcrb_unit

/* hw/pcrb_defs.svh */
`ifndef PCRB_DEFS_SVH
`define PCRB_DEFS_SVH
// Displacement shaping
`define PCRB_IMM_W      16
`define PCRB_DISP_SHIFT 2
`define PCRB_DISP_W     18
// Link register number and link offset (second instruction after the branch)
`define PCRB_LINK_REG   5'h1F
`define PCRB_LINK_OFS   32'h0000_0008
// Delay slot sits one word after the branch
`define PCRB_SLOT_OFS   32'h0000_0004
`define PCRB_ZERO_REG   5'h00
`endif

/* hw/pcrb_pkg.sv */
package pcrb_pkg;
  // Branch kinds handled by this unit
  typedef enum logic [2:0] {
    PCRB_OP_NONE,
    PCRB_OP_BRANCH_EQUAL_LIKELY,
    PCRB_OP_BRANCH_NONNEG,
    PCRB_OP_BRANCH_NONNEG_LIKELY,
    PCRB_OP_BRANCH_NONNEG_LINK,
    PCRB_OP_BRANCH_NONNEG_LINK_LIKELY
  } pcrb_op_e;

  // Branch request from decode
  typedef struct packed {
    pcrb_op_e    op;
    logic [4:0]  rs;
    logic [4:0]  rt;
    logic [15:0] imm;
    logic [31:0] pc;
  } pcrb_req_s;

  // Resolution result to fetch and writeback
  typedef struct packed {
    logic        redirect;
    logic [31:0] target;
    logic        squash_slot;
    logic        link_we;
    logic [4:0]  link_reg;
    logic [31:0] link_data;
  } pcrb_res_s;
endpackage : pcrb_pkg

/* verification/pcrb_gpr_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Register file stand-in
module pcrb_gpr_model (
  input  wire logic        i_clk,
  input  wire logic        i_ld_en,
  input  wire logic [4:0]  i_ld_idx,
  input  wire logic [31:0] i_ld_data,
  input  wire logic        i_link_we,
  input  wire logic [4:0]  i_link_reg,
  input  wire logic [31:0] i_link_data,
  input  wire logic [4:0]  i_rs,
  input  wire logic [4:0]  i_rt,
  output logic      [31:0] o_rs_val,
  output logic      [31:0] o_rt_val
);
  logic [31:0] regs [32];
  // Entry 0 stays writable so the unit must mask it
  always_ff @(posedge i_clk) begin
    if (i_link_we) begin
      regs[i_link_reg] <= i_link_data;
    end else if (i_ld_en) begin
      regs[i_ld_idx] <= i_ld_data;
    end
  end
  // Combinational reads, so a re-run sees the same state
  assign o_rs_val = regs[i_rs];
  assign o_rt_val = regs[i_rt];
endmodule : pcrb_gpr_model

/* verification/test_pc_relative_branch_unit.sv */
`timescale 1ns/100ps
module test_pc_relative_branch_unit;
  logic              clk, rst_n, valid, ld_en, redir, squash, lwe, exc;
  logic [4:0]        ld_idx, lreg;
  logic [31:0]       ld_data, rs_val, rt_val, target, ldata;
  pcrb_pkg::pcrb_req_s req;
  int                num_errors, n_compared, cycles;
  // ==========================================================
  // Clock, hang guard and instances
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Ceiling well above the fifty or so cycles used
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      test_done();
    end
  end
  pcrb_unit u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_valid(valid), .i_req(req),
    .i_rs_val(rs_val), .i_rt_val(rt_val), .o_redirect(redir), .o_target(target),
    .o_squash_slot(squash), .o_link_we(lwe), .o_link_reg(lreg), .o_link_data(ldata),
    .o_exception(exc));
  pcrb_gpr_model u_gpr (.i_clk(clk), .i_ld_en(ld_en), .i_ld_idx(ld_idx),
    .i_ld_data(ld_data), .i_link_we(lwe), .i_link_reg(lreg), .i_link_data(ldata),
    .i_rs(req.rs), .i_rt(req.rt), .o_rs_val(rs_val), .o_rt_val(rt_val));
  // ==========================================================
  // Shared tasks
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task test_done;
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // Loading also drops valid so no stray request is taken
  task load(input logic [4:0] idx, input logic [31:0] d);
    @(negedge clk);
    valid   = 1'b0;
    ld_en   = 1'b1;
    ld_idx  = idx;
    ld_data = d;
    @(negedge clk);
    ld_en = 1'b0;
  endtask : load
  // Op code follows the enum order; valid stays up for back-to-back use
  task go(input int op, input logic [4:0] rs, input logic [4:0] rt,
          input logic [15:0] imm, input logic [31:0] pc, input logic tk);
    logic        lk;
    logic [31:0] exp_tgt;
    lk      = (op >= 4);
    exp_tgt = pc + 32'h4 + {{14{imm[15]}}, imm, 2'h0};
    @(negedge clk);
    valid = 1'b1;
    req = '{pcrb_pkg::pcrb_op_e'(op), rs, rt, imm, pc};
    @(posedge clk);
    #1;
    chk("redirect", 32'(redir), 32'(tk));
    chk("squash", 32'(squash), 32'(op[0] && !tk));
    chk("link_we", 32'(lwe), 32'(lk));
    chk("exception", 32'(exc), 32'h0);
    if (tk) chk("target", target, exp_tgt);
    if (lk) chk("link_data", ldata, pc + 32'h8);
    if (lk) chk("link_reg", 32'(lreg), 32'h1F);
  endtask : go
  // A refused request must give no pulse at all
  task idle(input logic v, input int op);
    @(negedge clk);
    valid = v;
    req.op = pcrb_pkg::pcrb_op_e'(op);
    @(posedge clk);
    #1;
    chk("pulses", 32'({redir, squash, lwe}), 32'h0);
  endtask : idle
  // ==========================================================
  // Scenarios; no branch sits in a slot and no link form tests entry 31
  task t_equal;
    load(5'h01, 32'h1234_5678);
    load(5'h02, 32'h1234_5678);
    load(5'h03, 32'h1234_5679);
    go(1, 5'h01, 5'h02, 16'h8000, 32'h0000_1000, 1'b1);
    go(1, 5'h01, 5'h03, 16'h7FFF, 32'h0000_2000, 1'b0);
    idle(1'b0, 1);
  endtask : t_equal
  // Every nonneg form, sign bit clear then set; likely forms run as often as the others
  task t_nonneg;
    load(5'h04, 32'h7FFF_FFFF);
    load(5'h05, 32'h8000_0000);
    for (int i = 2; i <= 5; i++) begin
      go(i, 5'h04, 5'h00, 16'hFFFF, 32'h0000_3000, 1'b1);
      go(i, 5'h05, 5'h00, 16'h0001, 32'h0000_3100, 1'b0);
    end
    idle(1'b1, 0);
  endtask : t_nonneg
  // Entry 0 holds junk with the sign bit set
  task t_zero;
    load(5'h00, 32'h8000_0000);
    load(5'h06, 32'h0000_0000);
    go(4, 5'h00, 5'h00, 16'h0004, 32'h0000_0100, 1'b1);
    go(1, 5'h00, 5'h06, 16'h0002, 32'h0000_0200, 1'b1);
    idle(1'b0, 0);
  endtask : t_zero
  // Same branch twice, then entry 31 is compared with the link value
  task t_rerun;
    go(5, 5'h04, 5'h00, 16'h0010, 32'h0000_4000, 1'b1);
    go(5, 5'h04, 5'h00, 16'h0010, 32'h0000_4000, 1'b1);
    idle(1'b0, 0);
    load(5'h07, 32'h0000_4008);
    go(1, 5'h1F, 5'h07, 16'h0000, 32'h0000_5000, 1'b1);
    idle(1'b0, 0);
  endtask : t_rerun
  // Reset mid-run drops a pending branch and clears every pulse
  task t_reset;
    @(negedge clk);
    rst_n = 1'b0;
    valid = 1'b1;
    req   = '{pcrb_pkg::PCRB_OP_BRANCH_NONNEG_LINK, 5'h00, 5'h00, 16'h0004, 32'h0000_0100};
    @(posedge clk);
    #1;
    chk("reset_pulses", 32'({redir, squash, lwe}), 32'h0);
    chk("reset_target", target, 32'h0);
    chk("reset_link_reg", 32'(lreg), 32'h0);
    @(negedge clk);
    rst_n = 1'b1;
    valid = 1'b0;
    go(4, 5'h00, 5'h00, 16'h0004, 32'h0000_0100, 1'b1);
    idle(1'b0, 0);
  endtask : t_reset
  // ==========================================================
  // Main sequence
  initial begin
    rst_n   = 1'b0;
    valid   = 1'b0;
    ld_en   = 1'b0;
    ld_idx  = '0;
    ld_data = '0;
    req     = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_equal();
    t_nonneg();
    t_zero();
    t_rerun();
    t_reset();
    test_done();
  end
endmodule : test_pc_relative_branch_unit
